//--- hw/hrtc_top.sv
/*
 hrtc_top: always-on hibernation controller with seconds / sub-second rtc,
 trimmed pre-divider, match compare, low-battery watch, tamper enable and
 external regulator enable.
 assumes: clk and rst come from the battery-backed domain only; the
 32.768 kHz source, wake pin, battery comparator and tamper pin are async.
*/
`timescale 1ns/1ps
`default_nettype none
module hrtc_top
   import hrtc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [31:0]       wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output var  logic [31:0]       rdata,
   input  wire logic              ref32k_pin,
   input  wire logic              wake_pin,
   input  wire logic              batt_low_pin,
   input  wire logic              tamper_pin,
   output var  logic [1:0]        lowbatt_level_sel,
   output var  logic              regulator_en,
   output var  logic              irq
);

   // ----------------------------------------------------------------
   // input synchronisers and 32 kHz tick
   // ----------------------------------------------------------------
   logic [3:0]       sync_q;
   logic             ref_s;
   logic             wake_s;
   logic             batt_low_s;
   logic             tamper_s;
   logic             ref_prev_reg;
   logic             tamper_prev_reg;
   logic             tick;

   hrtc_sync #(.W(4)) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({tamper_pin, batt_low_pin, wake_pin, ref32k_pin}),
      .q   (sync_q)
   );
   assign {tamper_s, batt_low_s, wake_s, ref_s} = sync_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         ref_prev_reg    <= 1'b0;
         tamper_prev_reg <= 1'b0;
      end else begin
         ref_prev_reg    <= ref_s;
         tamper_prev_reg <= tamper_s;
      end
   end
   assign tick = ref_s & ~ref_prev_reg;

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   hrtc_ctrl_t       ctrl_reg;
   hrtc_tamper_cfg_t tcfg_reg;
   logic [31:0]      match_sec_reg;
   logic [SUB_W-1:0] match_sub_reg;
   logic [SUB_W-1:0] trim_reg;
   logic [RIS_W-1:0] imask_reg;
   logic             wr_ctrl;
   logic             wr_sec;
   logic             hib_req;

   assign wr_ctrl = wr & (addr == OFS_CTRL);
   assign wr_sec  = wr & (addr == OFS_SECONDS);
   assign hib_req = wr_ctrl & wdata[CTRL_REQ_BIT];

   // only rst (battery power-up) resets these; processor resets never reach
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_reg      <= '0;
         tcfg_reg      <= '0;
         match_sec_reg <= '0;
         match_sub_reg <= '0;
         trim_reg      <= TRIM_NOMINAL;
         imask_reg     <= '0;
      end else if (wr) begin
         unique case (addr)
            OFS_CTRL:      ctrl_reg      <= hrtc_ctrl_t'(wdata[CTRL_W-1:0]);
            OFS_TAMPER:    tcfg_reg      <= hrtc_tamper_cfg_t'(wdata[1:0]);
            OFS_MATCH_SEC: match_sec_reg <= wdata;
            OFS_MATCH_SUB: match_sub_reg <= wdata[SUB_W-1:0];
            OFS_TRIM:      trim_reg      <= wdata[SUB_W-1:0];
            OFS_IMASK:     imask_reg     <= wdata[RIS_W-1:0];
            default:       ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lowbatt_level_sel <= LOWBATT_LEVEL_LOWEST;
      end else begin
         lowbatt_level_sel <= ctrl_reg.lowbatt_level;
      end
   end

   // ----------------------------------------------------------------
   // pre-divider, sub-second and seconds counters
   // ----------------------------------------------------------------
   logic [31:0]      seconds_reg;
   logic [SUB_W-1:0] subsec_reg;
   logic [SUB_W-1:0] div_limit;
   logic             sec_roll;

   // trimmed period only in the second whose low six bits are zero
   assign div_limit = (seconds_reg[ROLL_W-1:0] == ROLL_ZERO) ? trim_reg
                                                             : TRIM_NOMINAL;
   assign sec_roll  = ctrl_reg.rtc_en & tick & (subsec_reg >= div_limit);

   always_ff @(posedge clk) begin
      if (rst) begin
         seconds_reg <= '0;
         subsec_reg  <= '0;
      end else if (wr_sec) begin
         seconds_reg <= wdata;
         subsec_reg  <= '0;
      end else if (sec_roll) begin
         seconds_reg <= seconds_reg + 32'h0000_0001;
         subsec_reg  <= '0;
      end else if (ctrl_reg.rtc_en & tick) begin
         subsec_reg  <= subsec_reg + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // match compare, seconds and sub-second value
   // ----------------------------------------------------------------
   logic match_eq;
   logic match_eq_prev_reg;
   logic match_evt;

   assign match_eq  = ctrl_reg.rtc_en & (seconds_reg == match_sec_reg)
                      & (subsec_reg == match_sub_reg);
   assign match_evt = match_eq & ~match_eq_prev_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         match_eq_prev_reg <= 1'b0;
      end else begin
         match_eq_prev_reg <= match_eq;
      end
   end

   // ----------------------------------------------------------------
   // event sources and raw status
   // ----------------------------------------------------------------
   logic             lowbatt_on;
   logic             tamper_hit;
   logic [RIS_W-1:0] ris_reg;
   logic [RIS_W-1:0] ris_set;
   logic [RIS_W-1:0] ris_clr;

   assign lowbatt_on = ctrl_reg.lowbatt_detect_only | ctrl_reg.lowbatt_abort_sleep;
   // disabled tamper stops detection only; tcfg_reg is untouched
   assign tamper_hit = ctrl_reg.tamper_en &
                       ((tamper_s ^ tamper_prev_reg) & (tamper_s == tcfg_reg.active_high));

   always_comb begin
      ris_set              = '0;
      ris_set[RIS_MATCH]   = match_evt;
      ris_set[RIS_LOWBATT] = lowbatt_on & batt_low_s;
      ris_set[RIS_PIN]     = wake_s;
      ris_set[RIS_TAMPER]  = tamper_hit;
   end
   assign ris_clr = (wr & (addr == OFS_ICLR)) ? wdata[RIS_W-1:0] : '0;

   // a new event in the clearing cycle stays set
   always_ff @(posedge clk) begin
      if (rst) begin
         ris_reg <= '0;
      end else begin
         ris_reg <= (ris_reg & ~ris_clr) | ris_set;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(ris_reg & imask_reg);
      end
   end

   // ----------------------------------------------------------------
   // hibernation sequencer
   // ----------------------------------------------------------------
   hrtc_state_t state_reg;
   logic        abort_now;
   logic        wake_now;

   assign abort_now = ctrl_reg.lowbatt_abort_sleep & batt_low_s;
   assign wake_now  = (ctrl_reg.wake_on_match & match_evt)
                    | (ctrl_reg.wake_on_pin & wake_s)
                    | (tcfg_reg.wake_on_tamper & tamper_hit);

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg    <= ST_RUN;
         regulator_en <= 1'b1;
      end else begin
         unique case (state_reg)
            ST_RUN: begin
               if (hib_req & ~abort_now) begin
                  state_reg    <= ST_HIB;
                  regulator_en <= 1'b0;
               end
            end
            ST_HIB: begin
               if (wake_now) begin
                  state_reg    <= ST_RUN;
                  regulator_en <= 1'b1;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= '0;
      end else if (rd) begin
         unique case (addr)
            OFS_CTRL:      rdata <= {24'h000000, ctrl_reg};
            OFS_SECONDS:   rdata <= seconds_reg;
            OFS_SUBSEC:    rdata <= {16'h0000, subsec_reg};
            OFS_MATCH_SEC: rdata <= match_sec_reg;
            OFS_MATCH_SUB: rdata <= {16'h0000, match_sub_reg};
            OFS_TRIM:      rdata <= {16'h0000, trim_reg};
            OFS_RIS:       rdata <= {28'h0000000, ris_reg};
            OFS_IMASK:     rdata <= {28'h0000000, imask_reg};
            OFS_TAMPER:    rdata <= {30'h0, tcfg_reg};
            OFS_STATUS:    rdata <= {29'h0, batt_low_s, state_reg, regulator_en};
            default:       rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_lowbatt_flag: assert property (@(posedge clk) disable iff (rst)
      lowbatt_on && batt_low_s |=> ris_reg[RIS_LOWBATT])
      else $error("low battery not flagged");

   a_abort_hold: assert property (@(posedge clk) disable iff (rst)
      state_reg == ST_RUN && hib_req && abort_now |=> state_reg == ST_RUN && regulator_en)
      else $error("hibernate not aborted on low battery");

   // level field sits at ctrl bits 4:3
   a_level_out: assert property (@(posedge clk) disable iff (rst)
      wr_ctrl |=> ##1 lowbatt_level_sel == $past(wdata[4:3], 2))
      else $error("battery level select not driven");

   // a wake may follow at once, so only the first cycle is fixed
   a_hib_off: assert property (@(posedge clk) disable iff (rst)
      state_reg == ST_RUN && hib_req && !abort_now |=> !regulator_en && state_reg == ST_HIB)
      else $error("regulator stays on after request");

   a_wake_on: assert property (@(posedge clk) disable iff (rst)
      state_reg == ST_HIB && wake_now |=> regulator_en && state_reg == ST_RUN)
      else $error("no wake on configured event");

   a_rtc_stop: assert property (@(posedge clk) disable iff (rst)
      !ctrl_reg.rtc_en && !wr_sec |=> $stable(seconds_reg) && $stable(subsec_reg))
      else $error("counters move while rtc off");

   a_sec_step: assert property (@(posedge clk) disable iff (rst)
      sec_roll && !wr_sec |=> seconds_reg == $past(seconds_reg) + 32'h0000_0001
                              && subsec_reg == '0)
      else $error("seconds roll incoherent");

   a_trim_period: assert property (@(posedge clk) disable iff (rst)
      ctrl_reg.rtc_en && tick && !wr_sec && seconds_reg[ROLL_W-1:0] != ROLL_ZERO
      && subsec_reg == TRIM_NOMINAL |=> subsec_reg == '0)
      else $error("nominal period not kept outside trim second");

   a_match_flag: assert property (@(posedge clk) disable iff (rst)
      ctrl_reg.rtc_en && seconds_reg == match_sec_reg && subsec_reg == match_sub_reg
      && !match_eq_prev_reg |=> ris_reg[RIS_MATCH])
      else $error("match not flagged");

   a_clear_bit: assert property (@(posedge clk) disable iff (rst)
      ris_clr[RIS_MATCH] && !match_evt |=> !ris_reg[RIS_MATCH])
      else $error("match flag not cleared");

endmodule
`default_nettype wire

//--- hw/hrtc_pkg.sv
/*
 hrtc_pkg: register map, field positions, reset values and types of the
 hibernation rtc and power controller.
 assumes: 32-bit register port with byte offsets, 100 MHz system clock.
*/
package hrtc_pkg;

   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam int            ADDR_W        = 8;
   localparam logic [7:0]    OFS_CTRL      = 8'h00;
   localparam logic [7:0]    OFS_SECONDS   = 8'h04;
   localparam logic [7:0]    OFS_SUBSEC    = 8'h08;
   localparam logic [7:0]    OFS_MATCH_SEC = 8'h0c;
   localparam logic [7:0]    OFS_MATCH_SUB = 8'h10;
   localparam logic [7:0]    OFS_TRIM      = 8'h14;
   localparam logic [7:0]    OFS_RIS       = 8'h18;
   localparam logic [7:0]    OFS_IMASK     = 8'h1c;
   localparam logic [7:0]    OFS_ICLR      = 8'h20;
   localparam logic [7:0]    OFS_TAMPER    = 8'h24;
   localparam logic [7:0]    OFS_STATUS    = 8'h28;

   // ----------------------------------------------------------------
   // fields
   // ----------------------------------------------------------------
   localparam int            CTRL_W        = 8;
   localparam int            CTRL_REQ_BIT  = 8;
   localparam int            RIS_W         = 4;
   localparam int            RIS_MATCH     = 0;
   localparam int            RIS_LOWBATT   = 1;
   localparam int            RIS_PIN       = 2;
   localparam int            RIS_TAMPER    = 3;
   localparam int            SUB_W         = 16;
   localparam int            ROLL_W        = 6;
   localparam logic [15:0]   TRIM_NOMINAL  = 16'h7fff;
   localparam logic [5:0]    ROLL_ZERO     = 6'h00;

   // low-battery trip levels, two-bit select
   localparam logic [1:0]    LOWBATT_LEVEL_LOWEST  = 2'h0;   // 1.9 V
   localparam logic [1:0]    LOWBATT_LEVEL_SECOND  = 2'h1;   // 2.1 V
   localparam logic [1:0]    LOWBATT_LEVEL_THIRD   = 2'h2;   // 2.3 V
   localparam logic [1:0]    LOWBATT_LEVEL_HIGHEST = 2'h3;   // 2.5 V

   typedef struct packed {
      logic       wake_on_pin;
      logic       wake_on_match;
      logic       tamper_en;
      logic [1:0] lowbatt_level;
      logic       lowbatt_abort_sleep;
      logic       lowbatt_detect_only;
      logic       rtc_en;
   } hrtc_ctrl_t;

   typedef struct packed {
      logic       wake_on_tamper;
      logic       active_high;
   } hrtc_tamper_cfg_t;

   typedef enum logic [0:0] {
      ST_RUN = 1'b0,
      ST_HIB = 1'b1
   } hrtc_state_t;

endpackage

//--- hw/hrtc_sync.sv
/*
 hrtc_sync: two-flop synchroniser for asynchronous level inputs.
 assumes: inputs are slow levels relative to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module hrtc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule
`default_nettype wire

//--- tb/hrtc_power_partner.sv
/*
 hrtc_power_partner: external regulator, processor supply and battery comparator.
 assumes: bench sets the battery level in millivolts; comparator is combinational.
*/
`timescale 1ns/1ps
`default_nettype none
module hrtc_power_partner
   import hrtc_pkg::*;
(
   input  wire logic [11:0] batt_mv,
   input  wire logic [1:0]  lowbatt_level_sel,
   input  wire logic        regulator_en,
   output var  logic        batt_low,
   output var  logic        cpu_powered
);
   // ----------------------------------------------------------------
   // comparator: 1.9 V plus 0.2 V per select step
   // ----------------------------------------------------------------
   always_comb begin
      batt_low = (batt_mv < (12'd1900 + 12'd200 * {10'h0, lowbatt_level_sel}));
   end
   // ----------------------------------------------------------------
   // regulator output follows its enable
   // ----------------------------------------------------------------
   always_comb begin
      cpu_powered = regulator_en;
   end
endmodule
`default_nettype wire

//--- tb/hrtc_top_bench.sv
/*
 hrtc_top_bench: self-checking bench of the hibernation controller.
 assumes: register map of hrtc_pkg, rdata valid one cycle after rd.
*/
`timescale 1ns/1ps
`default_nettype none
module hrtc_top_bench
   import hrtc_pkg::*;
;
   logic        clk, rst, wr, rd, ref32k_pin, wake_pin, tamper_pin, irq;
   logic        regulator_en, batt_low, cpu_powered;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, d;
   logic [1:0]  lowbatt_level_sel;
   logic [11:0] batt_mv;
   int          bad_count, n_tests;
   logic        seen_low;

   hrtc_top u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .ref32k_pin(ref32k_pin), .wake_pin(wake_pin),
      .batt_low_pin(batt_low), .tamper_pin(tamper_pin),
      .lowbatt_level_sel(lowbatt_level_sel), .regulator_en(regulator_en), .irq(irq));
   hrtc_power_partner u_pwr (.batt_mv(batt_mv), .lowbatt_level_sel(lowbatt_level_sel),
      .regulator_en(regulator_en), .batt_low(batt_low), .cpu_powered(cpu_powered));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= v; end
      @(posedge clk) wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk) begin rd <= 1'b1; addr <= a; end
      @(posedge clk) rd <= 1'b0;
      #1 v = rdata;
   endtask
   function automatic logic [31:0] cw(input logic rtc, det, ab, input logic [1:0] lvl,
                                      input logic tmp, wm, wp, req);
      return {23'h0, req, hrtc_ctrl_t'{wp, wm, tmp, lvl, ab, det, rtc}};
   endfunction
   task automatic tick(input int n);
      repeat (n) begin
         repeat (4) @(posedge clk) ref32k_pin <= 1'b1;
         repeat (4) @(posedge clk) ref32k_pin <= 1'b0;
      end
      repeat (4) @(posedge clk);
   endtask
   task automatic wait_reg(input logic v, input int lim);
      int i;
      for (i = 0; i < lim && regulator_en !== v; i++) @(posedge clk);
      #1;
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   typedef struct {logic [7:0] a; logic [31:0] v; logic [31:0] e;} row_t;
   row_t rows[7] = '{
      '{OFS_MATCH_SEC, 32'hdeadbeef, 32'hdeadbeef}, '{OFS_MATCH_SUB, 32'h12345678, 32'h5678},
      '{OFS_TRIM, 32'h00017ffe, 32'h7ffe}, '{OFS_TRIM, 32'h00007fff, 32'h7fff},
      '{OFS_IMASK, 32'h0000000f, 32'hf}, '{OFS_ICLR, 32'h0000000f, 32'h0},
      '{8'h3c, 32'h0000abcd, 32'h0}};

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end

   initial begin
      rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
      ref32k_pin = 1'b0; wake_pin = 1'b0; tamper_pin = 1'b0;
      batt_mv = 12'd3000; n_tests = 0; bad_count = 0; seen_low = 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      #1;
      check({31'h0, regulator_en}, 32'h1);
      check({31'h0, irq}, 32'h0);
      rd_reg(OFS_TRIM, d);
      check(d, {16'h0, TRIM_NOMINAL});
      $display("test reset done");
      // ----------------------------------------------------------------
      // register rows
      // ----------------------------------------------------------------
      foreach (rows[i]) begin
         wr_reg(rows[i].a, rows[i].v);
         rd_reg(rows[i].a, d);
         check(d, rows[i].e);
      end
      $display("test rows done");
      // ----------------------------------------------------------------
      // battery levels, detect, interrupt and clear
      // ----------------------------------------------------------------
      batt_mv = 12'd2200;
      for (int l = 0; l < 4; l++) begin
         wr_reg(OFS_CTRL, cw(1'b0, 1'b1, 1'b0, 2'(l), 1'b0, 1'b0, 1'b0, 1'b0));
         repeat (6) @(posedge clk);
         seen_low = seen_low | (l >= 2);
         check({30'h0, lowbatt_level_sel}, 32'(l));
         rd_reg(OFS_RIS, d);
         check(d & 32'h2, {30'h0, seen_low, 1'b0});
         check({31'h0, irq}, {31'h0, seen_low});
      end
      batt_mv = 12'd3000;
      repeat (6) @(posedge clk);
      wr_reg(OFS_ICLR, 32'h2);
      rd_reg(OFS_RIS, d);
      check(d & 32'h2, 32'h0);
      check({31'h0, irq}, 32'h0);
      $display("test lowbatt done");
      // ----------------------------------------------------------------
      // rtc enable gates the sub-second count
      // ----------------------------------------------------------------
      tick(3);
      rd_reg(OFS_SUBSEC, d);
      check(d, 32'h0);
      wr_reg(OFS_CTRL, cw(1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
      wr_reg(OFS_SECONDS, 32'h0);
      tick(3);
      rd_reg(OFS_SUBSEC, d);
      check(d, 32'h3);
      $display("test enable done");
      // ----------------------------------------------------------------
      // trimmed second, match wake from hibernation
      // ----------------------------------------------------------------
      wr_reg(OFS_MATCH_SEC, 32'h1);
      wr_reg(OFS_MATCH_SUB, 32'h0);
      wr_reg(OFS_TRIM, 32'h3);
      wr_reg(OFS_SECONDS, 32'h0);
      wr_reg(OFS_ICLR, 32'hf);
      wr_reg(OFS_CTRL, cw(1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1));
      repeat (2) @(posedge clk);
      #1 check({31'h0, cpu_powered}, 32'h0);
      tick(4);
      wait_reg(1'b1, 20);
      check({31'h0, regulator_en}, 32'h1);
      rd_reg(OFS_SECONDS, d);
      check(d, 32'h1);
      rd_reg(OFS_SUBSEC, d);
      check(d, 32'h0);
      rd_reg(OFS_RIS, d);
      check(d & 32'h1, 32'h1);
      rd_reg(OFS_MATCH_SEC, d);
      check(d, 32'h1);
      // seconds 1 is no trim second: four ticks must not roll
      tick(4);
      rd_reg(OFS_SECONDS, d);
      check(d, 32'h1);
      rd_reg(OFS_SUBSEC, d);
      check(d, 32'h4);
      $display("test match done");
      // ----------------------------------------------------------------
      // abort on low battery, then wake pin
      // ----------------------------------------------------------------
      batt_mv = 12'd2200;
      wr_reg(OFS_CTRL, cw(1'b1, 1'b1, 1'b1, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0));
      repeat (6) @(posedge clk);
      wr_reg(OFS_CTRL, cw(1'b1, 1'b1, 1'b1, 2'h3, 1'b0, 1'b0, 1'b0, 1'b1));
      repeat (4) @(posedge clk);
      #1 check({31'h0, regulator_en}, 32'h1);
      batt_mv = 12'd3000;
      repeat (6) @(posedge clk);
      wr_reg(OFS_CTRL, cw(1'b1, 1'b0, 1'b0, 2'h3, 1'b0, 1'b0, 1'b1, 1'b1));
      repeat (2) @(posedge clk);
      #1 check({31'h0, regulator_en}, 32'h0);
      rd_reg(OFS_STATUS, d);
      check(d, 32'h2);
      @(posedge clk) wake_pin <= 1'b1;
      wait_reg(1'b1, 10);
      check({31'h0, regulator_en}, 32'h1);
      @(posedge clk) wake_pin <= 1'b0;
      rd_reg(OFS_RIS, d);
      check(d & 32'h4, 32'h4);
      $display("test abort and pin done");
      // ----------------------------------------------------------------
      // tamper enable keeps its configuration
      // ----------------------------------------------------------------
      wr_reg(OFS_TAMPER, 32'h1);
      wr_reg(OFS_CTRL, cw(1'b1, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0));
      wr_reg(OFS_CTRL, cw(1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
      rd_reg(OFS_TAMPER, d);
      check(d, 32'h1);
      wr_reg(OFS_ICLR, 32'hf);
      wr_reg(OFS_CTRL, cw(1'b1, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0));
      @(posedge clk) tamper_pin <= 1'b1;
      repeat (6) @(posedge clk);
      rd_reg(OFS_RIS, d);
      check(d & 32'h8, 32'h8);
      // disabled tamper must not flag a new active edge
      @(posedge clk) tamper_pin <= 1'b0;
      wr_reg(OFS_CTRL, cw(1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
      wr_reg(OFS_ICLR, 32'hf);
      @(posedge clk) tamper_pin <= 1'b1;
      repeat (6) @(posedge clk);
      rd_reg(OFS_RIS, d);
      check(d & 32'h8, 32'h0);
      // tamper edge as wake source
      @(posedge clk) tamper_pin <= 1'b0;
      wr_reg(OFS_TAMPER, 32'h3);
      wr_reg(OFS_CTRL, cw(1'b1, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0, 1'b0, 1'b1));
      repeat (2) @(posedge clk);
      #1 check({31'h0, regulator_en}, 32'h0);
      @(posedge clk) tamper_pin <= 1'b1;
      wait_reg(1'b1, 10);
      check({31'h0, regulator_en}, 32'h1);
      $display("test tamper done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
